// ===== src/vdc_pkg.sv
/*
 Package for the video decoder control register bank: register indices,
 field positions, reset values, field codes and the carrier structs.
 Assumes a 32-bit APB with byte addresses equal to four times the index.
*/
`default_nettype none
package vdc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_ANALOG_CHANNEL_CONTROLS = 6'h01;
  localparam logic [5:0] IDX_OPERATION_MODE_CONTROLS = 6'h02;
  localparam logic [5:0] IDX_MISCELLANEOUS_CONTROL   = 6'h03;
  localparam logic [5:0] IDX_COLOR_KILLER_THRESHOLD  = 6'h06;
  localparam logic [5:0] IDX_OUTPUT_ENABLE_EXTRA     = 6'h08;
  localparam logic [5:0] IDX_BLOCK_STATUS            = 6'h09;

  // Analog channel controls fields
  localparam int AGC_LSB  = 0;
  localparam int OFS1_LSB = 2;
  localparam int OFS2_LSB = 4;
  // Operation mode fields
  localparam int PDN_BIT   = 0;
  localparam int SCFRZ_BIT = 2;
  localparam int TVVCR_LSB = 4;
  // Miscellaneous control fields
  localparam int CLKOE_BIT  = 0;
  localparam int VBON_BIT   = 1;
  localparam int TIMOE_BIT  = 3;
  localparam int DEC_OE_BIT = 4;
  localparam int INDSEL_BIT = 5;
  localparam int GPFN_LSB   = 6;
  // Color killer fields
  localparam int KTHR_LSB  = 0;
  localparam int KMODE_LSB = 5;
  // Extra output enable register
  localparam int VBI_OE_BIT = 0;

  // Two-bit field codes
  localparam logic [1:0] LOOP_AUTO   = 2'h1;
  localparam logic [1:0] LOOP_FREEZE = 2'h3;
  localparam logic [1:0] MODE_AUTO   = 2'h0;
  localparam logic [1:0] MODE_NONSTD = 2'h2;
  localparam logic [1:0] MODE_STD    = 2'h3;
  localparam logic [1:0] GP_LOW      = 2'h0;
  localparam logic [1:0] GP_HIGH     = 2'h1;
  localparam logic [1:0] GP_VBLANK   = 2'h2;
  localparam logic [1:0] GP_SYNCLOCK = 2'h3;
  localparam logic [1:0] KILL_AUTO   = 2'h0;
  localparam logic [1:0] KILL_FORCE  = 2'h2;
  localparam logic [1:0] KILL_OFF    = 2'h3;

  // Reset values
  localparam logic [1:0] RST_LOOP   = 2'h1;
  localparam logic [1:0] RST_MODE   = 2'h0;
  localparam logic       RST_SCFRZ  = 1'b0;
  localparam logic       RST_PDN    = 1'b0;
  localparam logic [1:0] RST_GPFN   = 2'h0;
  localparam logic       RST_INDSEL = 1'b0;
  localparam logic       RST_VBON   = 1'b0;
  localparam logic       RST_CLKOE  = 1'b1;
  localparam logic [1:0] RST_KMODE  = 2'h0;
  localparam logic [4:0] RST_KTHR   = 5'h00;
  localparam logic       RST_VBI_OE = 1'b1;

  // Threshold in tenths of dB of attenuation
  localparam logic [4:0] KTHR_MID     = 5'h10;
  localparam logic [8:0] KTHR_DB10_LO = 9'h0B4;
  localparam logic [8:0] KTHR_DB10_MD = 9'h0F0;

  localparam int GL_W = 16;

  // Decoder state seen by the bank, same clock domain
  typedef struct packed {
    logic              pal_indicator;
    logic              field_id;
    logic              horizontal_lock_status;
    logic              vertical_lock_status;
    logic              vblank;
    logic              sync_unstable;
    logic [GL_W-1:0]   phase_increment;
  } vdc_decoder_status_t;

  // Control outputs to the analog front end and decoder core
  typedef struct packed {
    logic ofs1_freeze;
    logic ofs2_freeze;
    logic agc_freeze;
    logic nonstd_mode;
    logic comb_enable;
    logic trap_enable;
    logic subcarrier_freeze;
    logic adc_power_down;
    logic clock_minimum;
    logic force_nominal;
    logic kill_auto;
    logic kill_force;
    logic kill_disable;
    logic [8:0] kill_threshold_db10;
  } vdc_core_ctrl_t;

endpackage
`default_nettype wire

// ===== src/vdc_regs.sv
/*
 Control register bank of a multi-standard video decoder with an APB slave.
 Assumes decoder status from logic on CLK_SYS_I; pins pass two flip-flops.
*/
// Behaviour
// - Offset control per channel: 01 automatic, 11 clamp frozen; 00, 10 reserved.
// - Gain control: 01 automatic from luma, 11 gain frozen.
// - Signal type: 00 auto detect, 10 nonstandard, 11 standard; 01 reserved.
// - Auto detect with unstable syncs goes nonstandard: combs off, trap on.
// - Subcarrier freeze 0 runs loop; 1 stops it; genlock pin follows.
// - Power down 1 stops converters and minimises clocks; 0 normal.
// - General pin: 00 low, 01 high, 10 vertical blank, 11 sync-lock input.
// - Sync-lock input high forces clocks and syncs to nominal values.
// - Indicator select 0 gives PAL and field; 1 gives lock status.
// - Video data enable bit 0 tristates luma/chroma buses, 1 drives.
// - Timing pin enable 0 tristates sync, active, PAL, field pins.
// - Both enable bits reset to the active-video strap level.
// - Vertical blank bit activates blank output on general pin.
// - Clock enable 1 drives sample and pixel clocks, 0 tristates.
// - Video data active only with enable pin low and both bits 1.
// - Before programming, strap high and enable pin low give active video.
// - Killer mode: 00 automatic, 10 chroma zero, 11 killing off.
// - Threshold 00000 -18 dB, 10000 -24 dB, 11111 -30 dB, interpolated.
`timescale 1ns/1ns
`default_nettype none
module vdc_regs (
  input  wire logic                        CLK_SYS_I,
  input  wire logic                        RST_N_I,
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [7:0]                  PADDR_I,
  input  wire logic [31:0]                 PWDATA_I,
  input  wire logic [3:0]                  PSTRB_I,
  output logic                             PREADY_O,
  output logic [31:0]                      PRDATA_O,
  output logic                             PSLVERR_O,
  input  wire vdc_pkg::vdc_decoder_status_t DEC_STATUS_I,
  output vdc_pkg::vdc_core_ctrl_t          CORE_CTRL_O,
  input  wire logic                        OUTPUT_ENABLE_PIN_N_I,
  input  wire logic                        AVID_STRAP_I,
  input  wire logic                        GENERAL_PURPOSE_PIN_I,
  output logic                             GENERAL_PURPOSE_PIN_O,
  output logic                             GENERAL_PURPOSE_PIN_OE_O,
  output logic                             PAL_INDICATOR_PIN_O,
  output logic                             FIELD_IDENTIFIER_PIN_O,
  output logic [vdc_pkg::GL_W-1:0]         GENLOCK_OUTPUT_PIN_O,
  output logic                             VIDEO_DATA_OE_O,
  output logic                             TIMING_PINS_OE_O,
  output logic                             CLOCK_PINS_OE_O
);

  typedef struct packed {
    logic                       oen_s1;
    logic                       oen_s2;
    logic                       avid_s1;
    logic                       avid_s2;
    logic                       gp_s1;
    logic                       gp_s2;

    logic [1:0]                 ofs1;
    logic [1:0]                 ofs2;
    logic [1:0]                 agc;
    logic [1:0]                 mode;
    logic                       scfrz;
    logic                       pdn;
    logic [1:0]                 gpfn;
    logic                       indsel;
    logic                       dec_oe;
    logic                       timoe;
    logic                       vbon;
    logic                       clkoe;
    logic [1:0]                 kmode;
    logic [4:0]                 kthr;
    logic                       vbi_oe;
    logic                       strap;
    logic [vdc_pkg::GL_W-1:0]   gl_hold;

    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;

    vdc_pkg::vdc_core_ctrl_t    ctrl;
    logic                       gp_o;
    logic                       gp_oe;
    logic                       pal_o;
    logic                       fld_o;
    logic [vdc_pkg::GL_W-1:0]   gl_o;
    logic                       video_oe;
    logic                       tim_oe;
    logic                       clk_oe;
  } vdc_state_t;

  vdc_state_t st_r;
  vdc_state_t st_nxt;

  logic [5:0]  idx;
  logic        mapped;
  logic        wr_en;
  logic [7:0]  wb;

  logic [31:0] rd_val;
  logic [8:0]  db10;
  logic        nonstd;

  assign idx = PADDR_I[7:2];
  assign wb  = PWDATA_I[7:0];
  // Writes land on the single access edge where pready is sampled high
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & st_r.pready & PSTRB_I[0] & mapped
                 & (idx != vdc_pkg::IDX_BLOCK_STATUS);

  always_comb
  begin
    unique case (idx)
      vdc_pkg::IDX_ANALOG_CHANNEL_CONTROLS,
      vdc_pkg::IDX_OPERATION_MODE_CONTROLS,
      vdc_pkg::IDX_MISCELLANEOUS_CONTROL,
      vdc_pkg::IDX_COLOR_KILLER_THRESHOLD,
      vdc_pkg::IDX_OUTPUT_ENABLE_EXTRA,
      vdc_pkg::IDX_BLOCK_STATUS: mapped = 1'b1;
      default:                   mapped = 1'b0;
    endcase
  end

  // Read mux; unused and reserved bits stay zero
  always_comb
  begin
    rd_val = 32'h0000_0000;

    unique case (idx)
      vdc_pkg::IDX_ANALOG_CHANNEL_CONTROLS:
      begin
        rd_val[vdc_pkg::AGC_LSB +: 2]  = st_r.agc;
        rd_val[vdc_pkg::OFS1_LSB +: 2] = st_r.ofs1;
        rd_val[vdc_pkg::OFS2_LSB +: 2] = st_r.ofs2;
      end

      vdc_pkg::IDX_OPERATION_MODE_CONTROLS:
      begin
        rd_val[vdc_pkg::PDN_BIT]        = st_r.pdn;
        rd_val[vdc_pkg::SCFRZ_BIT]      = st_r.scfrz;
        rd_val[vdc_pkg::TVVCR_LSB +: 2] = st_r.mode;
      end

      vdc_pkg::IDX_MISCELLANEOUS_CONTROL:
      begin
        rd_val[vdc_pkg::CLKOE_BIT]     = st_r.clkoe;
        rd_val[vdc_pkg::VBON_BIT]      = st_r.vbon;
        rd_val[vdc_pkg::TIMOE_BIT]     = st_r.timoe;
        rd_val[vdc_pkg::DEC_OE_BIT]    = st_r.dec_oe;
        rd_val[vdc_pkg::INDSEL_BIT]    = st_r.indsel;
        rd_val[vdc_pkg::GPFN_LSB +: 2] = st_r.gpfn;
      end

      vdc_pkg::IDX_COLOR_KILLER_THRESHOLD:
      begin
        rd_val[vdc_pkg::KTHR_LSB +: 5]  = st_r.kthr;
        rd_val[vdc_pkg::KMODE_LSB +: 2] = st_r.kmode;
      end

      vdc_pkg::IDX_OUTPUT_ENABLE_EXTRA:
      begin
        rd_val[vdc_pkg::VBI_OE_BIT] = st_r.vbi_oe;
      end

      vdc_pkg::IDX_BLOCK_STATUS:
      begin
        rd_val[0] = st_r.ctrl.nonstd_mode;
        rd_val[1] = st_r.ctrl.force_nominal;
        rd_val[2] = st_r.video_oe;
        rd_val[3] = st_r.strap;
        rd_val[4] = DEC_STATUS_I.horizontal_lock_status;
        rd_val[5] = DEC_STATUS_I.vertical_lock_status;
      end

      default:
      begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // Threshold code to attenuation in tenths of dB, two linear segments
  always_comb
  begin
    if (st_r.kthr < vdc_pkg::KTHR_MID)
    begin
      db10 = vdc_pkg::KTHR_DB10_LO + 9'((13'(st_r.kthr) * 13'd15) >> 2);
    end
    else
    begin
      db10 = vdc_pkg::KTHR_DB10_MD + 9'(11'(st_r.kthr - vdc_pkg::KTHR_MID) * 11'd4);
    end
  end

  // Auto mode falls back to nonstandard handling on unstable syncs
  assign nonstd = (st_r.mode == vdc_pkg::MODE_NONSTD)
                | ((st_r.mode == vdc_pkg::MODE_AUTO) & DEC_STATUS_I.sync_unstable);

  always_comb
  begin
    st_nxt = st_r;

    // Pin synchronisers
    st_nxt.oen_s1  = OUTPUT_ENABLE_PIN_N_I;
    st_nxt.oen_s2  = st_r.oen_s1;
    st_nxt.avid_s1 = AVID_STRAP_I;
    st_nxt.avid_s2 = st_r.avid_s1;
    st_nxt.gp_s1   = GENERAL_PURPOSE_PIN_I;
    st_nxt.gp_s2   = st_r.gp_s1;

    // APB: pready rises for the first access cycle, so no wait states
    st_nxt.pready  = PSEL_I & ~PENABLE_I;
    st_nxt.pslverr = PSEL_I & ~PENABLE_I & ~mapped;
    st_nxt.prdata  = (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rd_val : 32'h0000_0000;

    // Unlisted bits are never stored
    if (wr_en)
    begin
      unique case (idx)
        vdc_pkg::IDX_ANALOG_CHANNEL_CONTROLS:
        begin
          // Reserved codes leave the field as it was
          if (wb[vdc_pkg::OFS1_LSB])
            st_nxt.ofs1 = wb[vdc_pkg::OFS1_LSB +: 2];
          if (wb[vdc_pkg::OFS2_LSB])
            st_nxt.ofs2 = wb[vdc_pkg::OFS2_LSB +: 2];
          if (wb[vdc_pkg::AGC_LSB])
            st_nxt.agc = wb[vdc_pkg::AGC_LSB +: 2];
        end

        vdc_pkg::IDX_OPERATION_MODE_CONTROLS:
        begin
          if (wb[vdc_pkg::TVVCR_LSB +: 2] != 2'h1)
            st_nxt.mode = wb[vdc_pkg::TVVCR_LSB +: 2];

          st_nxt.scfrz = wb[vdc_pkg::SCFRZ_BIT];
          st_nxt.pdn   = wb[vdc_pkg::PDN_BIT];
        end

        vdc_pkg::IDX_MISCELLANEOUS_CONTROL:
        begin
          st_nxt.gpfn   = wb[vdc_pkg::GPFN_LSB +: 2];
          st_nxt.indsel = wb[vdc_pkg::INDSEL_BIT];
          st_nxt.dec_oe = wb[vdc_pkg::DEC_OE_BIT];
          st_nxt.timoe  = wb[vdc_pkg::TIMOE_BIT];
          st_nxt.vbon   = wb[vdc_pkg::VBON_BIT];
          st_nxt.clkoe  = wb[vdc_pkg::CLKOE_BIT];
        end

        vdc_pkg::IDX_COLOR_KILLER_THRESHOLD:
        begin
          if (wb[vdc_pkg::KMODE_LSB +: 2] != 2'h1)
            st_nxt.kmode = wb[vdc_pkg::KMODE_LSB +: 2];
          st_nxt.kthr = wb[vdc_pkg::KTHR_LSB +: 5];
        end

        vdc_pkg::IDX_OUTPUT_ENABLE_EXTRA:
        begin
          st_nxt.vbi_oe = wb[vdc_pkg::VBI_OE_BIT];
        end

        default:
        begin
          st_nxt.vbi_oe = st_r.vbi_oe;
        end
      endcase
    end

    // Genlock value holds the last increment while the loop is frozen
    if (!st_r.scfrz)
      st_nxt.gl_hold = DEC_STATUS_I.phase_increment;
    st_nxt.gl_o = st_r.scfrz ? st_r.gl_hold : DEC_STATUS_I.phase_increment;

    st_nxt.ctrl.ofs1_freeze       = (st_r.ofs1 == vdc_pkg::LOOP_FREEZE);
    st_nxt.ctrl.ofs2_freeze       = (st_r.ofs2 == vdc_pkg::LOOP_FREEZE);
    st_nxt.ctrl.agc_freeze        = (st_r.agc == vdc_pkg::LOOP_FREEZE);

    st_nxt.ctrl.nonstd_mode       = nonstd;
    st_nxt.ctrl.comb_enable       = ~nonstd;
    st_nxt.ctrl.trap_enable       = nonstd;
    st_nxt.ctrl.subcarrier_freeze = st_r.scfrz;
    st_nxt.ctrl.adc_power_down    = st_r.pdn;
    st_nxt.ctrl.clock_minimum     = st_r.pdn;

    st_nxt.ctrl.force_nominal     = (st_r.gpfn == vdc_pkg::GP_SYNCLOCK) & st_r.gp_s2;

    st_nxt.ctrl.kill_auto         = (st_r.kmode == vdc_pkg::KILL_AUTO);
    st_nxt.ctrl.kill_force        = (st_r.kmode == vdc_pkg::KILL_FORCE);
    st_nxt.ctrl.kill_disable      = (st_r.kmode == vdc_pkg::KILL_OFF);
    st_nxt.ctrl.kill_threshold_db10 = db10;

    // General pin: released only in sync-lock input mode
    unique case (st_r.gpfn)
      vdc_pkg::GP_LOW:    st_nxt.gp_o = 1'b0;
      vdc_pkg::GP_HIGH:   st_nxt.gp_o = 1'b1;
      vdc_pkg::GP_VBLANK: st_nxt.gp_o = st_r.vbon & DEC_STATUS_I.vblank;
      vdc_pkg::GP_SYNCLOCK: st_nxt.gp_o = 1'b0;
    endcase

    st_nxt.gp_oe = (st_r.gpfn != vdc_pkg::GP_SYNCLOCK);

    st_nxt.pal_o = st_r.indsel ? DEC_STATUS_I.horizontal_lock_status
                               : DEC_STATUS_I.pal_indicator;

    st_nxt.fld_o = st_r.indsel ? DEC_STATUS_I.vertical_lock_status
                               : DEC_STATUS_I.field_id;

    // Pin high always wins; bits reset from the strap cover the unprogrammed case
    st_nxt.video_oe = ~st_r.oen_s2 & st_r.dec_oe & st_r.vbi_oe;
    st_nxt.tim_oe   = st_r.timoe;
    st_nxt.clk_oe   = st_r.clkoe;

    if (!RST_N_I)
    begin
      st_nxt.ofs1      = vdc_pkg::RST_LOOP;
      st_nxt.ofs2      = vdc_pkg::RST_LOOP;
      st_nxt.agc       = vdc_pkg::RST_LOOP;
      st_nxt.mode      = vdc_pkg::RST_MODE;
      st_nxt.scfrz     = vdc_pkg::RST_SCFRZ;
      st_nxt.pdn       = vdc_pkg::RST_PDN;
      st_nxt.gpfn      = vdc_pkg::RST_GPFN;
      st_nxt.indsel    = vdc_pkg::RST_INDSEL;

      // Strap caught while reset is held, through the synchroniser
      st_nxt.strap     = st_r.avid_s2;
      st_nxt.dec_oe    = st_r.avid_s2;
      st_nxt.timoe     = st_r.avid_s2;
      st_nxt.vbon      = vdc_pkg::RST_VBON;
      st_nxt.clkoe     = vdc_pkg::RST_CLKOE;
      st_nxt.kmode     = vdc_pkg::RST_KMODE;
      st_nxt.kthr      = vdc_pkg::RST_KTHR;
      st_nxt.vbi_oe    = vdc_pkg::RST_VBI_OE;
      st_nxt.gl_hold   = '0;

      // Bus idle, pins at safe levels
      st_nxt.pready    = 1'b0;
      st_nxt.pslverr   = 1'b0;
      st_nxt.prdata    = 32'h0000_0000;
      st_nxt.ctrl      = '0;
      st_nxt.gp_o      = 1'b0;
      st_nxt.gp_oe     = 1'b1;
      st_nxt.pal_o     = 1'b0;
      st_nxt.fld_o     = 1'b0;
      st_nxt.gl_o      = '0;
      st_nxt.video_oe  = 1'b0;
      st_nxt.tim_oe    = 1'b0;
      st_nxt.clk_oe    = vdc_pkg::RST_CLKOE;
    end
  end

  // Whole state in one register
  always_ff @(posedge CLK_SYS_I)
  begin
    st_r <= st_nxt;
  end

  assign PREADY_O                 = st_r.pready;
  assign PRDATA_O                 = st_r.prdata;
  assign PSLVERR_O                = st_r.pslverr;
  assign CORE_CTRL_O              = st_r.ctrl;

  assign GENERAL_PURPOSE_PIN_O    = st_r.gp_o;
  assign GENERAL_PURPOSE_PIN_OE_O = st_r.gp_oe;
  assign PAL_INDICATOR_PIN_O      = st_r.pal_o;
  assign FIELD_IDENTIFIER_PIN_O   = st_r.fld_o;
  assign GENLOCK_OUTPUT_PIN_O     = st_r.gl_o;
  assign VIDEO_DATA_OE_O          = st_r.video_oe;
  assign TIMING_PINS_OE_O         = st_r.tim_oe;
  assign CLOCK_PINS_OE_O          = st_r.clk_oe;

endmodule
`default_nettype wire

// ===== verif/vdc_regs_assertions.sv
/*
 Concurrent checks on the control register bank, seeing only its ports.
 Assumes one clock domain; bound at the foot.
*/
`timescale 1ns/1ns
`default_nettype none
module vdc_regs_assertions (
  input wire logic                    CLK_SYS_I,
  input wire logic                    RST_N_I,
  input wire logic                    PSEL_I,
  input wire logic                    PENABLE_I,
  input wire logic                    PWRITE_I,
  input wire logic [7:0]              PADDR_I,
  input wire logic [31:0]             PWDATA_I,
  input wire logic [3:0]              PSTRB_I,
  input wire logic                    PREADY_O,
  input wire logic [31:0]             PRDATA_O,
  input wire logic                    PSLVERR_O,
  input wire vdc_pkg::vdc_core_ctrl_t CORE_CTRL_O,
  input wire logic                    OUTPUT_ENABLE_PIN_N_I,
  input wire logic                    GENERAL_PURPOSE_PIN_I,
  input wire logic                    GENERAL_PURPOSE_PIN_OE_O,
  input wire logic [15:0]             GENLOCK_OUTPUT_PIN_O,
  input wire logic                    VIDEO_DATA_OE_O,
  input wire logic                    CLOCK_PINS_OE_O
);
  logic [2:0] up_cnt_r;
  logic       mapped, wr_edge;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  // Outputs lag reset release
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
      up_cnt_r <= 3'h0;
    else if (up_cnt_r != 3'h4)
      up_cnt_r <= up_cnt_r + 3'h1;
  end
  assign mapped = PADDR_I[7:2] inside {vdc_pkg::IDX_ANALOG_CHANNEL_CONTROLS,
    vdc_pkg::IDX_OPERATION_MODE_CONTROLS, vdc_pkg::IDX_MISCELLANEOUS_CONTROL,
    vdc_pkg::IDX_COLOR_KILLER_THRESHOLD, vdc_pkg::IDX_OUTPUT_ENABLE_EXTRA,
    vdc_pkg::IDX_BLOCK_STATUS};
  assign wr_edge = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0];
  a_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no ready");
  a_ready_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("stray ready");
  a_slverr_map: assert property (
    PSEL_I && !PENABLE_I |=> PSLVERR_O != $past(mapped))
    else $error("slverr vs map");
  a_upper_zero: assert property (
    PREADY_O |-> PRDATA_O[31:8] == 24'h00_0000 && (!PSLVERR_O || PRDATA_O == 32'h0000_0000))
    else $error("high bits set");
  a_pdn_write: assert property (
    wr_edge && PADDR_I[7:2] == vdc_pkg::IDX_OPERATION_MODE_CONTROLS |-> ##2
    CORE_CTRL_O.adc_power_down == $past(PWDATA_I[vdc_pkg::PDN_BIT], 2))
    else $error("power down write");
  a_pdn_clocks: assert property (
    CORE_CTRL_O.adc_power_down == CORE_CTRL_O.clock_minimum)
    else $error("clock reduction");
  a_clk_oe_write: assert property (
    wr_edge && PADDR_I[7:2] == vdc_pkg::IDX_MISCELLANEOUS_CONTROL |-> ##2
    CLOCK_PINS_OE_O == $past(PWDATA_I[vdc_pkg::CLKOE_BIT], 2))
    else $error("clock enable write");
  a_oe_pin_off: assert property (OUTPUT_ENABLE_PIN_N_I [*5] |-> !VIDEO_DATA_OE_O)
    else $error("video driven, pin high");
  a_nonstd_filters: assert property (
    CORE_CTRL_O.nonstd_mode |-> !CORE_CTRL_O.comb_enable && CORE_CTRL_O.trap_enable)
    else $error("filters in nonstandard");
  a_kill_onehot: assert property (
    up_cnt_r == 3'h4 |->
    $onehot({CORE_CTRL_O.kill_auto, CORE_CTRL_O.kill_force, CORE_CTRL_O.kill_disable}))
    else $error("kill mode not one-hot");
  a_thresh_range: assert property (
    up_cnt_r == 3'h4 |->
    CORE_CTRL_O.kill_threshold_db10 inside {[vdc_pkg::KTHR_DB10_LO:9'h12C]})
    else $error("kill threshold span");
  a_sync_force: assert property (
    (!GENERAL_PURPOSE_PIN_OE_O && GENERAL_PURPOSE_PIN_I) [*5] |-> CORE_CTRL_O.force_nominal)
    else $error("sync-lock not forced");
  a_freeze_hold: assert property (
    CORE_CTRL_O.subcarrier_freeze [*3] |-> $stable(GENLOCK_OUTPUT_PIN_O))
    else $error("genlock moved frozen");
endmodule
bind vdc_regs vdc_regs_assertions u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
  .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .CORE_CTRL_O(CORE_CTRL_O),
  .OUTPUT_ENABLE_PIN_N_I(OUTPUT_ENABLE_PIN_N_I), .GENERAL_PURPOSE_PIN_I(GENERAL_PURPOSE_PIN_I),
  .GENERAL_PURPOSE_PIN_OE_O(GENERAL_PURPOSE_PIN_OE_O),
  .GENLOCK_OUTPUT_PIN_O(GENLOCK_OUTPUT_PIN_O), .VIDEO_DATA_OE_O(VIDEO_DATA_OE_O),
  .CLOCK_PINS_OE_O(CLOCK_PINS_OE_O)
);
`default_nettype wire

// ===== verif/tb_vdc_regs.sv
/*
 Self-checking bench for the control register bank, driven over APB.
 Assumes the bound checker; one 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_vdc_regs;
  localparam AN = vdc_pkg::IDX_ANALOG_CHANNEL_CONTROLS;
  localparam OP = vdc_pkg::IDX_OPERATION_MODE_CONTROLS;
  localparam MI = vdc_pkg::IDX_MISCELLANEOUS_CONTROL;
  localparam KI = vdc_pkg::IDX_COLOR_KILLER_THRESHOLD;
  localparam EX = vdc_pkg::IDX_OUTPUT_ENABLE_EXTRA;
  localparam ST = vdc_pkg::IDX_BLOCK_STATUS;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, oe_n, strap, gp_i;
  logic        gp_o, gp_oe, pal_o, fld_o, vid_oe, tim_oe, clk_oe, sc, ns;
  logic [1:0]  c, f, m;
  logic [3:0]  pstrb, stb;
  logic [4:0]  t;
  logic [7:0]  paddr;
  logic [15:0] genlock, gl;
  logic [31:0] pwdata, prdata, r;
  logic [32:0] q_e, rdq[$];
  int          errors, tests_run, seed, db;
  vdc_pkg::vdc_decoder_status_t dec_st;
  vdc_pkg::vdc_core_ctrl_t      core;
  vdc_regs uut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready), .PRDATA_O(prdata),
    .PSLVERR_O(pslverr), .DEC_STATUS_I(dec_st), .CORE_CTRL_O(core),
    .OUTPUT_ENABLE_PIN_N_I(oe_n), .AVID_STRAP_I(strap), .GENERAL_PURPOSE_PIN_I(gp_i),
    .GENERAL_PURPOSE_PIN_O(gp_o), .GENERAL_PURPOSE_PIN_OE_O(gp_oe), .PAL_INDICATOR_PIN_O(pal_o),
    .FIELD_IDENTIFIER_PIN_O(fld_o), .GENLOCK_OUTPUT_PIN_O(genlock), .VIDEO_DATA_OE_O(vid_oe),
    .TIMING_PINS_OE_O(tim_oe), .CLOCK_PINS_OE_O(clk_oe)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic done(input string nm);
    $display("finished %s", nm);
  endtask
  // Expected answer queued at setup
  task automatic apb(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic err);
    int n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {a, 2'b00};
    pstrb   <= stb;
    pwdata  <= {24'($random(seed)), d};
    rdq.push_back({err, 24'h00_0000, w ? 8'h00 : e});
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      errors++;
      end_of_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pin paths lag up to three edges
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      q_e = rdq.size() > 0 ? rdq.pop_front() : 33'h1_FFFF_FFFF;
      chk("prdata", q_e[31:0], prdata);
      chk("pslverr", 32'(q_e[32]), 32'(pslverr));
    end
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial
  begin
    seed = 32'h501c_cbd5;
    errors = 0;
    tests_run = 0;
    {rst_n, psel, penable, pwrite, oe_n, gp_i, sc} = 7'h00;
    {paddr, pwdata, dec_st, gl} = '0;
    strap = 1'b1;
    stb = 4'hF;
    pstrb = 4'hF;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, AN, 0, 8'h15, 0);
    apb(0, OP, 0, 8'h00, 0);
    apb(0, MI, 0, 8'h19, 0);
    apb(0, KI, 0, 8'h00, 0);
    apb(0, EX, 0, 8'h01, 0);
    apb(1, ST, 8'hFF, 0, 0);
    apb(0, ST, 0, 8'h0C, 0);
    apb(1, 6'h05, 8'h5A, 0, 1);
    apb(0, 6'h3F, 0, 0, 1);
    stb = 4'hE;
    apb(1, AN, 8'h3F, 0, 0);
    stb = 4'hF;
    apb(0, AN, 0, 8'h15, 0);
    settle();
    chk("vid_oe", 32'h1, 32'(vid_oe));
    chk("tim_oe", 32'h1, 32'(tim_oe));
    chk("kill_thr", 32'h0B4, 32'(core.kill_threshold_db10));
    done("reset values");
    f = 2'h1;
    for (int i = 3; i >= 0; i--)
    begin
      c = 2'(i);
      if (c[0])
        f = c;
      apb(1, AN, {2'b11, c, c, c}, 0, 0);
      apb(0, AN, 0, {2'b00, f, f, f}, 0);
      settle();
      chk("freezes", 32'({3{f == 2'h3}}),
          32'({core.ofs1_freeze, core.ofs2_freeze, core.agc_freeze}));
    end
    done("offset and gain");
    m = 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      c = 2'(i >> 1);
      if (c != 2'h1)
        m = c;
      dec_st.sync_unstable <= i[0];
      dec_st.phase_increment <= r[15:0];
      apb(1, OP, {2'b11, c, 1'b1, r[2], 1'b1, r[0]}, 0, 0);
      apb(0, OP, 0, {2'b00, m, 1'b0, r[2], 1'b0, r[0]}, 0);
      settle();
      dec_st.phase_increment <= r[31:16];
      settle();
      if (r[2] && !sc)
        gl = r[15:0];
      if (!r[2])
        gl = r[31:16];
      sc = r[2];
      ns = (m == 2'h2) || (m == 2'h0 && i[0]);
      chk("nonstd", 32'({ns, !ns, ns}),
          32'({core.nonstd_mode, core.comb_enable, core.trap_enable}));
      chk("pdn", 32'({2{r[0]}}), 32'({core.adc_power_down, core.clock_minimum}));
      chk("sc_freeze", 32'(r[2]), 32'(core.subcarrier_freeze));
      chk("genlock", 32'(gl), 32'(genlock));
    end
    done("operation mode");
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      c = 2'(i);
      dec_st <= r[21:0];
      gp_i <= r[30];
      oe_n <= r[31] & r[23];
      apb(1, MI, {c, r[29:27], 1'b1, r[25:24]}, 0, 0);
      apb(0, MI, 0, {c, r[29:27], 1'b0, r[25:24]}, 0);
      apb(1, EX, {7'h7F, r[22]}, 0, 0);
      apb(0, EX, 0, {7'h00, r[22]}, 0);
      settle();
      chk("gp_oe", 32'(c != 2'h3), 32'(gp_oe));
      if (c != 2'h3)
        chk("gp_o", 32'(c == 2'h1 || (c == 2'h2 && r[25] && r[17])), 32'(gp_o));
      chk("force_nom", 32'(c == 2'h3 && r[30]), 32'(core.force_nominal));
      chk("pal_fld", 32'(r[29] ? r[19:18] : r[21:20]), 32'({pal_o, fld_o}));
      chk("vid_oe", 32'(!(r[31] & r[23]) && r[28] && r[22]), 32'(vid_oe));
      chk("tim_clk_oe", 32'({r[27], r[24]}), 32'({tim_oe, clk_oe}));
    end
    done("pins and enables");
    m = 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      c = 2'(i);
      t = i == 0 ? 5'h00 : i == 1 ? 5'h10 : i == 2 ? 5'h1F : r[4:0];
      if (c != 2'h1)
        m = c;
      db = t < 5'h10 ? 180 + (t * 15) / 4 : 240 + (t - 16) * 4;
      apb(1, KI, {1'b1, c, t}, 0, 0);
      apb(0, KI, 0, {1'b0, m, t}, 0);
      settle();
      chk("kill_mode", 32'({m == 2'h0, m == 2'h2, m == 2'h3}),
          32'({core.kill_auto, core.kill_force, core.kill_disable}));
      chk("kill_thr", 32'(db), 32'(core.kill_threshold_db10));
    end
    done("color killer");
    rst_n <= 1'b0;
    strap <= 1'b0;
    oe_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, MI, 0, 8'h01, 0);
    apb(0, AN, 0, 8'h15, 0);
    settle();
    chk("vid_oe", 32'h0, 32'(vid_oe));
    apb(1, MI, 8'h19, 0, 0);
    settle();
    chk("vid_oe", 32'h1, 32'(vid_oe));
    oe_n <= 1'b1;
    settle();
    chk("vid_oe", 32'h0, 32'(vid_oe));
    done("strap low reset");
    chk("queue", 32'h0, 32'(rdq.size()));
    end_of_test();
  end
endmodule
`default_nettype wire
